//--- logic/flash_array_ctrl.sv
// Purpose: erase/program sequencer of one flash array, APB slave
// Assumes: array macro takes address, data, write strobe and modes
// Notes:   mass erase is not supported; mass select refuses high voltage only while high voltage is off
`timescale 1ns/100ps
`include "flash_ctrl_defs.svh"

module flash_array_ctrl
    import flash_seq_pkg::*;
#(
    parameter int unsigned SETUP_CYCLES = `SETUP_BEFORE_HV_CYCLES
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    output logic      [15:0] array_addr,
    output logic      [7:0]  array_wdata,
    output logic             array_write,
    output logic             array_prog,
    output logic             array_erase,
    output logic             array_hv,
    output logic             array_standby
);
    function automatic logic is_protected(input logic [15:0] a,
                                          input logic [7:0]  p);
        is_protected = (p != `PROTECT_RST) && (a >= {1'b0, p, 7'h00});
    endfunction

    seq_state_t  state_q;
    seq_state_t  state_d;
    logic        pgm_q;
    logic        erase_q;
    logic        mass_q;
    logic        hv_q;
    logic [7:0]  protect_q;
    logic [15:0] addr_q;
    logic        row_fail_q;
    logic        hv_refuse_q;
    logic        standby_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [15:0] arr_addr_q;
    logic [7:0]  arr_data_q;
    logic        arr_write_q;
    logic        setup_done;

    row_check_if rc ();

    // Bus decode
    wire setup_ph   = psel & ~penable;
    wire acc        = psel & penable & pready_q;
    wire wr_acc     = acc & pwrite;
    wire rd_acc     = acc & ~pwrite;
    wire sel_ctrl   = (paddr == `CTRL_OFS);
    wire sel_prot   = (paddr == `PROTECT_OFS);
    wire sel_status = (paddr == `STATUS_OFS);
    wire sel_addr   = (paddr == `ADDR_OFS);
    wire sel_data   = (paddr == `DATA_OFS);
    wire hit = sel_ctrl | sel_prot | sel_status | sel_addr | sel_data;

    wire wr_ctrl   = wr_acc & sel_ctrl;
    wire wr_prot   = wr_acc & sel_prot;
    wire wr_status = wr_acc & sel_status;
    wire wr_addr   = wr_acc & sel_addr;
    wire wr_data   = wr_acc & sel_data;
    wire rd_prot   = rd_acc & sel_prot;

    wire standby   = wait_mode | stop_mode;

    wire req_pgm   = pwdata[`PGM_BIT];
    wire req_erase = pwdata[`ERASE_BIT];
    wire req_both  = req_pgm & req_erase;
    wire pgm_new   = req_both ? pgm_q : req_pgm;
    wire erase_new = req_both ? erase_q : req_erase;

    wire hv_ok = (state_q == S_LATCHED) & setup_done
               & (pgm_new | erase_new) & ~pwdata[`MASS_BIT]
               & ~is_protected(arr_addr_q, protect_q);
    wire hv_req    = wr_ctrl & pwdata[`HV_BIT] & ~hv_q;
    wire hv_refuse = hv_req & ~hv_ok;

    wire pgm_d   = standby ? 1'b0 : (wr_ctrl ? pgm_new : pgm_q);
    wire erase_d = standby ? 1'b0 : (wr_ctrl ? erase_new : erase_q);
    wire mass_d  = standby ? 1'b0
                 : (wr_ctrl ? pwdata[`MASS_BIT] : mass_q);
    wire hv_d    = standby ? 1'b0
                 : (wr_ctrl ? pwdata[`HV_BIT] & (hv_q | hv_ok) : hv_q);
    wire any_sel = pgm_d | erase_d;

    wire latch_evt = wr_data & ~standby & (state_q == S_ARMED);
    wire prog_wr   = wr_data & ~standby & (state_q == S_HV_ON) & pgm_q;
    wire row_fail  = rc.fail;
    wire write_d   = latch_evt | (prog_wr & ~row_fail);

    assign rc.load  = latch_evt;
    assign rc.check = prog_wr;
    assign rc.addr  = addr_q;

    row_check u_row
    (
        .pclk    (pclk),
        .presetn (presetn),
        .rc      (rc)
    );

    seq_timer #(.CYCLES(SETUP_CYCLES)) u_setup
    (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (latch_evt),
        .clr     (state_d == S_IDLE),
        .done    (setup_done)
    );

    // Sequence steps
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
                if (any_sel)
                    state_d = S_SELECTED;
            S_SELECTED:
                if (!any_sel)
                    state_d = S_IDLE;
                else if (rd_prot)
                    state_d = S_ARMED;
            S_ARMED:
                if (!any_sel)
                    state_d = S_IDLE;
                else if (latch_evt)
                    state_d = S_LATCHED;
            S_LATCHED:
                if (hv_d)
                    state_d = S_HV_ON;
                else if (!any_sel)
                    state_d = S_IDLE;
            S_HV_ON:
                if (!hv_d)
                    state_d = S_IDLE;
            default:
                state_d = S_IDLE;
        endcase
        if (standby)
            state_d = S_IDLE;
    end

    wire [31:0] ctrl_rd = {28'h0000000, hv_q, mass_q, erase_q, pgm_q};
    wire [31:0] stat_rd = {25'h0000000, standby_q, setup_done,
                           hv_refuse_q, row_fail_q, state_q};
    wire [31:0] rdata_d = sel_ctrl   ? ctrl_rd
                        : sel_prot   ? {24'h000000, protect_q}
                        : sel_status ? stat_rd
                        : sel_addr   ? {16'h0000, addr_q}
                        : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end
        else
        begin
            pready_q  <= setup_ph;
            pslverr_q <= setup_ph & ~hit;
            if (setup_ph)
                prdata_q <= pwrite ? 32'h00000000 : rdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= S_IDLE;
            pgm_q   <= 1'b0;
            erase_q <= 1'b0;
            mass_q  <= 1'b0;
            hv_q    <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            pgm_q   <= pgm_d;
            erase_q <= erase_d;
            mass_q  <= mass_d;
            hv_q    <= hv_d;
        end
    end

    // Status flags, set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            row_fail_q  <= 1'b0;
            hv_refuse_q <= 1'b0;
            standby_q   <= 1'b0;
        end
        else
        begin
            row_fail_q  <= (prog_wr & row_fail) | (row_fail_q
                         & ~(wr_status & pwdata[`ST_ROWFAIL]));
            hv_refuse_q <= hv_refuse | (hv_refuse_q
                         & ~(wr_status & pwdata[`ST_HVREFUSE]));
            standby_q   <= standby;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            protect_q <= `PROTECT_RST;
            addr_q    <= 16'h0000;
        end
        else
        begin
            if (wr_prot)
                protect_q <= pwdata[7:0];
            if (wr_addr)
                addr_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            arr_addr_q  <= 16'h0000;
            arr_data_q  <= `ERASED_BYTE;
            arr_write_q <= 1'b0;
        end
        else
        begin
            arr_write_q <= write_d;
            if (write_d)
            begin
                arr_addr_q <= addr_q;
                arr_data_q <= pwdata[7:0];
            end
        end
    end

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign array_addr    = arr_addr_q;
    assign array_wdata   = arr_data_q;
    assign array_write   = arr_write_q;
    assign array_prog    = pgm_q;
    assign array_erase   = erase_q;
    assign array_hv      = hv_q;
    assign array_standby = standby_q;
endmodule

//--- logic/flash_ctrl_defs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB, 12-bit byte address, one word per register
// Notes:   included by the sequencer, the port checks and the testbench
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH

`define CTRL_OFS      12'h000
`define PROTECT_OFS   12'h004
`define STATUS_OFS    12'h008
`define ADDR_OFS      12'h00C
`define DATA_OFS      12'h010

`define PGM_BIT       0
`define ERASE_BIT     1
`define MASS_BIT      2
`define HV_BIT        3

`define ST_STATE_LSB  0
`define ST_ROWFAIL    3
`define ST_HVREFUSE   4
`define ST_SETUPMET   5
`define ST_STANDBY    6

`define PROTECT_RST   8'hFF
`define ERASED_BYTE   8'hFF

`define CLK_PERIOD_PS        8000
`define SETUP_BEFORE_HV_NS   10000
`define SETUP_BEFORE_HV_CYCLES \
    ((`SETUP_BEFORE_HV_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

//--- logic/flash_seq_pkg.sv
// Purpose: shared types of the flash array sequencer
// Assumes: nothing
// Notes:   numbers live in flash_ctrl_defs.svh
package flash_seq_pkg;

    typedef enum logic [2:0]
    {
        S_IDLE,
        S_SELECTED,
        S_ARMED,
        S_LATCHED,
        S_HV_ON
    } seq_state_t;

endpackage

//--- logic/row_check_if.sv
// Purpose: carries row tracking between sequencer and row checker
// Assumes: one clock, owner drives load and check
// Notes:   fail is combinational from the checker
`timescale 1ns/100ps

interface row_check_if;
    logic        load;
    logic        check;
    logic [15:0] addr;
    logic        fail;

    modport owner
    (
        output load,
        output check,
        output addr,
        input  fail
    );

    modport tracker
    (
        input  load,
        input  check,
        input  addr,
        output fail
    );
endinterface

//--- logic/seq_timer.sv
// Purpose: counts the setup interval after a latching write
// Assumes: start is a one-cycle pulse
// Notes:   done stays high until clr or a new start
`timescale 1ns/100ps

module seq_timer
    import flash_seq_pkg::*;
#(
    parameter int unsigned CYCLES = 1250
)
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic start,
    input  wire logic clr,
    output logic      done
);
    logic [15:0] cnt_q;
    logic        run_q;
    logic        done_q;

    assign done = done_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q  <= 16'h0000;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end
        else if (start)
        begin
            cnt_q  <= CYCLES[15:0];
            run_q  <= 1'b1;
            done_q <= 1'b0;
        end
        else if (clr)
        begin
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end
        else if (run_q)
        begin
            cnt_q  <= cnt_q - 16'h0001;
            run_q  <= (cnt_q != 16'h0001);
            done_q <= (cnt_q == 16'h0001);
        end
    end
endmodule

//--- logic/row_check.sv
// Purpose: remembers the latched row and flags writes outside it
// Assumes: rows are 64 aligned bytes, so row = addr[15:6]
// Notes:   fail only means something while check is high
`timescale 1ns/100ps

module row_check
    import flash_seq_pkg::*;
(
    input  wire logic    pclk,
    input  wire logic    presetn,
    row_check_if.tracker rc
);
    logic [9:0] row_q;

    assign rc.fail = rc.check & (rc.addr[15:6] != row_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            row_q <= 10'h000;
        else if (rc.load)
            row_q <= rc.addr[15:6];
    end
endmodule

//--- sim/flash_ctrl_props.sv
// Purpose: port checks of the flash sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound into every flash_array_ctrl
`timescale 1ns/100ps
`include "flash_ctrl_defs.svh"

module flash_ctrl_props
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        wait_mode,
    input wire logic        stop_mode,
    input wire logic [15:0] array_addr,
    input wire logic [7:0]  array_wdata,
    input wire logic        array_write,
    input wire logic        array_prog,
    input wire logic        array_erase,
    input wire logic        array_hv,
    input wire logic        array_standby
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic       ctrl_wr;
    logic [9:0] row_q;
    assign ctrl_wr = psel && penable && pwrite && paddr == `CTRL_OFS;

    // Row taken by the latching write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            row_q <= '0;
        else if (array_write && !array_hv)
            row_q <= array_addr[15:6];
    end

    sel_excl_a: assert property (
        !(array_prog && array_erase)) else $error("both selects set");
    hv_rise_a: assert property (
        $rose(array_hv) |-> $past(ctrl_wr && pwdata[`HV_BIT])
        && (array_prog || array_erase)) else $error("voltage rose badly");
    ready_a: assert property (
        psel && !penable |=> pready) else $error("no ready");
    ready_len_a: assert property (
        pready |-> psel && penable ##1 !pready) else $error("ready length");
    err_a: assert property (
        pslverr |-> pready) else $error("error without ready");
    write_sel_a: assert property (
        array_write |-> array_prog || array_erase) else $error("stray write");
    addr_chg_a: assert property (
        $changed(array_addr) |-> array_write) else $error("address moved");
    row_a: assert property (
        array_write && array_hv |-> array_addr[15:6] == row_q)
        else $error("write outside row");
    standby_a: assert property (
        wait_mode || stop_mode |=> array_standby && !array_hv
        && !array_prog && !array_erase) else $error("standby left active");
    standby_dly_a: assert property (
        1'b1 |=> array_standby == $past(wait_mode || stop_mode))
        else $error("standby delay");
endmodule

bind flash_array_ctrl flash_ctrl_props props_u
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wait_mode, .stop_mode, .array_addr,
    .array_wdata, .array_write, .array_prog, .array_erase, .array_hv,
    .array_standby
);

//--- sim/flash_array_model.sv
// Purpose: behavioural flash array behind the sequencer
// Assumes: 64K bytes, erased value FF
// Notes:   counts every write pulse it sees
`timescale 1ns/100ps

module flash_array_model
(
    input wire logic        pclk,
    input wire logic [15:0] array_addr,
    input wire logic [7:0]  array_wdata,
    input wire logic        array_write,
    input wire logic        array_prog,
    input wire logic        array_erase,
    input wire logic        array_hv
);
    logic [7:0] mem [0:65535];
    int         writes;

    initial
    begin
        writes = 0;
        foreach (mem[i])
            mem[i] = 8'hFF;
    end

    always @(posedge pclk)
    begin
        if (array_write)
            writes++;
        if (array_hv && array_erase)
            for (int i = 0; i < 128; i++)
                mem[{array_addr[15:7], 7'(i)}] = 8'hFF;
        if (array_write && array_prog && array_hv)
            mem[array_addr] = mem[array_addr] & array_wdata;
    end
endmodule

//--- sim/flash_array_erase_program_control_tb.sv
// Purpose: APB-driven test of the flash sequencer
// Assumes: setup count shortened to 8 cycles
// Notes:   array side is the behavioural model
`timescale 1ns/100ps
`include "flash_ctrl_defs.svh"

module flash_array_erase_program_control_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        wait_mode = 0, stop_mode = 0, pready, pslverr, err;
    logic        array_write, array_prog, array_erase, array_hv;
    logic        array_standby;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [15:0] array_addr;
    logic [7:0]  array_wdata;
    int          miscompares = 0, num_checks = 0;

    // Timing waits scaled down for run length
    localparam int HOLD_CYC = 16;
    localparam int GAP_CYC  = 4;

    always #4 pclk = ~pclk;

    flash_array_ctrl #(.SETUP_CYCLES(8)) dut_u
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .wait_mode, .stop_mode, .array_addr,
        .array_wdata, .array_write, .array_prog, .array_erase, .array_hv,
        .array_standby
    );

    flash_array_model mdl_u
    (
        .pclk, .array_addr, .array_wdata, .array_write, .array_prog,
        .array_erase, .array_hv
    );

    task results();
        if (miscompares == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            $display("[FAIL] %0t bus timeout", $time);
            miscompares++;
            results();
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(rd, e);
    endtask

    task arm(input logic [31:0] ctrl, input logic [15:0] a);
        wr(`CTRL_OFS, ctrl);
        apb(1'b0, `PROTECT_OFS, '0);
        wr(`ADDR_OFS, 32'(a));
        wr(`DATA_OFS, 32'h0);
    endtask

    task wait_setup();
        int n;
        n = 0;
        rd = '0;
        while (rd[`ST_SETUPMET] !== 1'b1 && n < 30)
        begin
            apb(1'b0, `STATUS_OFS, '0);
            n++;
        end
        if (rd[`ST_SETUPMET] !== 1'b1)
        begin
            $display("[FAIL] %0t setup timeout", $time);
            miscompares++;
            results();
        end
    endtask

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`PROTECT_OFS, 32'hFF);
        rdchk(`STATUS_OFS, 32'h0);
        apb(1'b0, 12'h020, '0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        wr(`DATA_OFS, 32'h0);
        wr(`CTRL_OFS, 32'h3);
        rdchk(`CTRL_OFS, 32'h0);
        chk(32'(mdl_u.writes), 32'h0);
        arm(32'h1, 16'h1040);
        wr(`CTRL_OFS, 32'h9);
        apb(1'b0, `STATUS_OFS, '0);
        chk(rd[`ST_HVREFUSE], 1'b1);
        wait_setup();
        wr(`CTRL_OFS, 32'h9);
        @(negedge pclk);
        chk(array_hv, 1'b1);
        chk(32'(mdl_u.writes), 32'h1);
        repeat (GAP_CYC) @(posedge pclk);
        wr(`ADDR_OFS, 32'h1041);
        wr(`DATA_OFS, 32'hA5);
        repeat (GAP_CYC) @(posedge pclk);
        wr(`ADDR_OFS, 32'h1080);
        wr(`DATA_OFS, 32'h5A);
        repeat (GAP_CYC) @(posedge pclk);
        apb(1'b0, `STATUS_OFS, '0);
        chk(rd[`ST_ROWFAIL], 1'b1);
        chk(mdl_u.mem[16'h1041], 8'hA5);
        chk(mdl_u.mem[16'h1080], 8'hFF);
        wr(`CTRL_OFS, 32'h8);
        repeat (GAP_CYC) @(posedge pclk);
        wr(`CTRL_OFS, 32'h0);
        apb(1'b0, `STATUS_OFS, '0);
        chk(rd[2:0], 3'h0);
        arm(32'h2, 16'h1010);
        wait_setup();
        wr(`CTRL_OFS, 32'hA);
        repeat (HOLD_CYC) @(posedge pclk);
        wr(`CTRL_OFS, 32'h8);
        repeat (GAP_CYC) @(posedge pclk);
        wr(`CTRL_OFS, 32'h0);
        chk(mdl_u.mem[16'h1041], 8'hFF);
        wr(`PROTECT_OFS, 32'h20);
        arm(32'h1, 16'h1040);
        wait_setup();
        wr(`CTRL_OFS, 32'h9);
        @(negedge pclk);
        chk(array_hv, 1'b0);
        wr(`CTRL_OFS, 32'h0);
        wr(`PROTECT_OFS, 32'hFF);
        for (int i = 0; i < 2; i++)
        begin
            arm(32'h1, 16'h1040);
            wait_setup();
            wr(`CTRL_OFS, 32'h9);
            @(posedge pclk);
            wait_mode <= (i == 0);
            stop_mode <= (i == 1);
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk({array_hv, array_prog, array_standby}, 3'b001);
            @(posedge pclk);
            wait_mode <= 1'b0;
            stop_mode <= 1'b0;
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk(array_standby, 1'b0);
            rdchk(`CTRL_OFS, 32'h0);
        end
        results();
    end
endmodule
